/* File: rtl/pwr_pkg.sv */
package pwr_pkg;
    // ----------------------------------------
    // register map (byte addresses)
    // ----------------------------------------
    localparam logic [3:0] ADDR_CLK_CTRL = 4'h0;
    localparam logic [3:0] ADDR_OPTION = 4'h4;
    localparam logic [3:0] ADDR_STATUS = 4'h8;

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int SLOW_SEL_BIT = 0;
    localparam int PRESC_LSB = 1;
    localparam int OSC_IRQ_EN_BIT = 3;
    localparam logic [3:0] CLK_CTRL_RST = 4'h0;
    localparam int OPT_DLY_BIT = 0;
    localparam int OPT_WDG_BIT = 1;
    localparam logic [1:0] OPTION_RST = 2'h0;

    // ----------------------------------------
    // timing, in cpu clock cycles
    // ----------------------------------------
    localparam logic [12:0] STAB_SHORT_CYC = 13'h0100;
    localparam logic [12:0] STAB_LONG_CYC = 13'h1000;

    // ----------------------------------------
    // codes
    // ----------------------------------------
    localparam logic [7:0] HALT_OPCODE = 8'h8E;
    localparam logic [1:0] COND_MASK_WAKE = 2'h2;
    localparam int IRQ_NUM = 14;
    localparam logic [2:0] MODE_RUN = 3'h0;
    localparam logic [2:0] MODE_SLOW = 3'h1;
    localparam logic [2:0] MODE_WAIT = 3'h2;
    localparam logic [2:0] MODE_SLOW_WAIT = 3'h3;
    localparam logic [2:0] MODE_ACT_HALT = 3'h4;
    localparam logic [2:0] MODE_HALT = 3'h5;
    localparam logic [2:0] MODE_STAB = 3'h6;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_WAIT,
        ST_AHALT,
        ST_HALT,
        ST_STAB
    } pwr_state_t;
endpackage : pwr_pkg

/* File: rtl/pwr_clk_div.sv */
`timescale 1ns/1ps
module pwr_clk_div (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic slowEn,
    input wire logic [1:0] prescale,
    output logic tick
);
    logic [3:0] cnt_r;
    logic [3:0] limit;

    // divide by 2, 4, 8 or 16 when slow, every cycle otherwise
    assign limit = 4'((5'h2 << prescale) - 5'h1);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cnt_r <= 4'h0;
        end else if (!slowEn || cnt_r >= limit) begin
            cnt_r <= 4'h0;
        end else begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick <= 1'b0;
        end else begin
            tick <= !slowEn || (cnt_r >= limit);
        end
    end
endmodule : pwr_clk_div

/* File: rtl/pwr_mode_ctrl.sv */
// Our own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
module pwr_mode_ctrl #(
    parameter bit FLASH_PART = 1'b1
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic instrValid,
    input wire logic [7:0] instrOpcode,
    input wire logic waitForIrqInstr,
    input wire logic [pwr_pkg::IRQ_NUM-1:0] irqPending,
    input wire logic [pwr_pkg::IRQ_NUM-1:0] wakeFromHalt,
    input wire logic [pwr_pkg::IRQ_NUM-1:0] wakeFromActHalt,
    input wire logic timebaseIrq,
    input wire logic resetReq,
    input wire logic watchdogEnabled,
    output logic cpuClkEn_r,
    output logic periphClkEn_r,
    output logic timebaseClkEn_r,
    output logic oscOn_r,
    output logic condMaskForce_r,
    output logic irqServiceReq_r,
    output logic rstVectorReq_r,
    output logic watchdogResetReq_r,
    output logic [2:0] modeCode_r
);
    // ----------------------------------------
    // declarations
    // ----------------------------------------
    pwr_pkg::pwr_state_t state_r;
    logic [3:0] clkCtrl_r;
    logic [1:0] option_r;
    logic [12:0] stabCnt_r;
    logic stabForReset_r;
    logic cpuTick;
    logic haltOp;
    logic oscIrqEn;
    logic wdgHaltOpt;
    logic anyIrq;
    logic haltWake;
    logic ahaltWake;
    logic busWrite;
    logic [12:0] stabLoad;

    // ----------------------------------------
    // decode helpers
    // ----------------------------------------
    function automatic logic wakeHit(input logic [pwr_pkg::IRQ_NUM-1:0] pend,
                                     input logic [pwr_pkg::IRQ_NUM-1:0] qual);
        wakeHit = |(pend & qual);
    endfunction : wakeHit

    function automatic logic [2:0] modeOf(input pwr_pkg::pwr_state_t st, input logic slow);
        case (st)
            pwr_pkg::ST_RUN: modeOf = slow ? pwr_pkg::MODE_SLOW : pwr_pkg::MODE_RUN;
            pwr_pkg::ST_WAIT: modeOf = slow ? pwr_pkg::MODE_SLOW_WAIT : pwr_pkg::MODE_WAIT;
            pwr_pkg::ST_AHALT: modeOf = pwr_pkg::MODE_ACT_HALT;
            pwr_pkg::ST_HALT: modeOf = pwr_pkg::MODE_HALT;
            default: modeOf = pwr_pkg::MODE_STAB;
        endcase
    endfunction : modeOf

    assign haltOp = instrValid && (instrOpcode == pwr_pkg::HALT_OPCODE);
    assign oscIrqEn = clkCtrl_r[pwr_pkg::OSC_IRQ_EN_BIT];
    assign wdgHaltOpt = option_r[pwr_pkg::OPT_WDG_BIT];
    assign anyIrq = (|irqPending) || timebaseIrq;
    assign haltWake = wakeHit(irqPending, wakeFromHalt);
    // flash parts lose the external wake sources in active-halt
    assign ahaltWake = timebaseIrq || (!FLASH_PART && wakeHit(irqPending, wakeFromActHalt));
    assign stabLoad = option_r[pwr_pkg::OPT_DLY_BIT] ? pwr_pkg::STAB_LONG_CYC : pwr_pkg::STAB_SHORT_CYC;

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    // one wait cycle; a write takes effect on the edge that sees waitrequest low, read data is registered on the edge before it
    assign busWrite = avs_write && !avs_waitrequest;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && avs_waitrequest) begin
            case (avs_address)
                pwr_pkg::ADDR_CLK_CTRL: avs_readdata <= {28'h000_0000, clkCtrl_r};
                pwr_pkg::ADDR_OPTION: avs_readdata <= {30'h0000_0000, option_r};
                pwr_pkg::ADDR_STATUS: avs_readdata <= {29'h0000_0000, modeCode_r};
                default: avs_readdata <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            clkCtrl_r <= pwr_pkg::CLK_CTRL_RST;
        end else if (busWrite && avs_address == pwr_pkg::ADDR_CLK_CTRL) begin
            clkCtrl_r <= avs_writedata[3:0];
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            option_r <= pwr_pkg::OPTION_RST;
        end else if (busWrite && avs_address == pwr_pkg::ADDR_OPTION) begin
            option_r <= avs_writedata[1:0];
        end
    end

    // ----------------------------------------
    // cpu clock divider
    // ----------------------------------------
    pwr_clk_div u_div (
        .clk_sys(clk_sys),
        .rst(rst),
        .slowEn(clkCtrl_r[pwr_pkg::SLOW_SEL_BIT]),
        .prescale(clkCtrl_r[pwr_pkg::PRESC_LSB +: 2]),
        .tick(cpuTick)
    );

    // ----------------------------------------
    // mode state machine
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_r <= pwr_pkg::ST_RUN;
        end else begin
            case (state_r)
                pwr_pkg::ST_RUN: begin
                    if (haltOp) begin
                        if (oscIrqEn) begin
                            state_r <= pwr_pkg::ST_AHALT;
                        end else if (!(watchdogEnabled && wdgHaltOpt)) begin
                            state_r <= pwr_pkg::ST_HALT;
                        end
                    end else if (waitForIrqInstr) begin
                        state_r <= pwr_pkg::ST_WAIT;
                    end
                end
                pwr_pkg::ST_WAIT: begin
                    if (resetReq || anyIrq) begin
                        state_r <= pwr_pkg::ST_RUN;
                    end
                end
                pwr_pkg::ST_AHALT: begin
                    if (resetReq) begin
                        state_r <= pwr_pkg::ST_STAB;
                    end else if (ahaltWake) begin
                        state_r <= pwr_pkg::ST_RUN;
                    end
                end
                pwr_pkg::ST_HALT: begin
                    if (resetReq || haltWake) begin
                        state_r <= pwr_pkg::ST_STAB;
                    end
                end
                pwr_pkg::ST_STAB: begin
                    if (stabCnt_r == 13'h0000 && cpuTick) begin
                        state_r <= pwr_pkg::ST_RUN;
                    end
                end
                default: state_r <= pwr_pkg::ST_RUN;
            endcase
        end
    end

    // stabilization delay counted in cpu cycles
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stabCnt_r <= 13'h0000;
        end else if (state_r != pwr_pkg::ST_STAB) begin
            stabCnt_r <= 13'(stabLoad - 13'h0001);
        end else if (cpuTick && stabCnt_r != 13'h0000) begin
            stabCnt_r <= stabCnt_r - 13'h0001;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            stabForReset_r <= 1'b0;
        end else if (state_r == pwr_pkg::ST_AHALT || state_r == pwr_pkg::ST_HALT) begin
            stabForReset_r <= resetReq;
        end
    end

    // ----------------------------------------
    // events toward core and watchdog
    // ----------------------------------------
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            condMaskForce_r <= 1'b0;
            watchdogResetReq_r <= 1'b0;
        end else begin
            // core loads the wake mask level on this pulse
            condMaskForce_r <= state_r == pwr_pkg::ST_RUN
                               && (haltOp ? (oscIrqEn || !(watchdogEnabled && wdgHaltOpt))
                                          : waitForIrqInstr);
            watchdogResetReq_r <= state_r == pwr_pkg::ST_RUN && haltOp && !oscIrqEn
                                  && watchdogEnabled && wdgHaltOpt;
        end
    end

    // core pushes the condition codes on this pulse before vectoring
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            irqServiceReq_r <= 1'b0;
            rstVectorReq_r <= 1'b0;
        end else begin
            irqServiceReq_r <= (state_r == pwr_pkg::ST_WAIT && !resetReq && anyIrq)
                               || (state_r == pwr_pkg::ST_AHALT && !resetReq && ahaltWake)
                               || (state_r == pwr_pkg::ST_STAB && stabCnt_r == 13'h0000 && cpuTick
                                   && !stabForReset_r);
            rstVectorReq_r <= (state_r == pwr_pkg::ST_WAIT && resetReq)
                              || (state_r == pwr_pkg::ST_STAB && stabCnt_r == 13'h0000 && cpuTick
                                  && stabForReset_r);
        end
    end

    // ----------------------------------------
    // clock gating
    // ----------------------------------------
    // oscillator drop in halt also stops the timebase; only external clocks survive
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cpuClkEn_r <= 1'b0;
            periphClkEn_r <= 1'b0;
            timebaseClkEn_r <= 1'b0;
            oscOn_r <= 1'b1;
        end else begin
            cpuClkEn_r <= cpuTick && state_r == pwr_pkg::ST_RUN;
            periphClkEn_r <= cpuTick && (state_r == pwr_pkg::ST_RUN || state_r == pwr_pkg::ST_WAIT);
            timebaseClkEn_r <= cpuTick && state_r != pwr_pkg::ST_HALT;
            oscOn_r <= state_r != pwr_pkg::ST_HALT;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            modeCode_r <= pwr_pkg::MODE_RUN;
        end else begin
            modeCode_r <= modeOf(state_r, clkCtrl_r[pwr_pkg::SLOW_SEL_BIT]);
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    sequence sHaltRun;
        state_r == pwr_pkg::ST_RUN && haltOp;
    endsequence
    sequence sHaltPlain;
        sHaltRun ##0 (!oscIrqEn && !(watchdogEnabled && wdgHaltOpt));
    endsequence

    chk_halt_entry: assert property (sHaltPlain |=> state_r == pwr_pkg::ST_HALT && condMaskForce_r)
        else $error("halt entry wrong");
    chk_ahalt_nowdg: assert property (sHaltRun ##0 oscIrqEn
        |=> state_r == pwr_pkg::ST_AHALT && !watchdogResetReq_r)
        else $error("active-halt entry wrong");
    chk_wdg_halt_reset: assert property (sHaltRun ##0 (!oscIrqEn && watchdogEnabled && wdgHaltOpt)
        |=> watchdogResetReq_r && state_r == pwr_pkg::ST_RUN)
        else $error("watchdog halt reset missing");
    chk_wait_mask: assert property (state_r == pwr_pkg::ST_RUN && waitForIrqInstr && !haltOp
        |=> state_r == pwr_pkg::ST_WAIT && condMaskForce_r)
        else $error("wait entry wrong");
    chk_wait_cpu_off: assert property ($past(state_r) == pwr_pkg::ST_WAIT |-> !cpuClkEn_r)
        else $error("cpu clocked in wait");
    chk_halt_clocks_off: assert property ($past(state_r) == pwr_pkg::ST_HALT
        |-> !oscOn_r && !cpuClkEn_r && !periphClkEn_r && !timebaseClkEn_r)
        else $error("clock running in halt");
    chk_ahalt_clocks: assert property ($past(state_r) == pwr_pkg::ST_AHALT
        |-> oscOn_r && !periphClkEn_r && !cpuClkEn_r)
        else $error("active-halt gating wrong");
    chk_ahalt_fast_exit: assert property (state_r == pwr_pkg::ST_AHALT && !resetReq && ahaltWake
        |=> state_r == pwr_pkg::ST_RUN && irqServiceReq_r)
        else $error("active-halt irq exit delayed");
    chk_stab_hold: assert property (state_r == pwr_pkg::ST_STAB && stabCnt_r != 13'h0000
        |=> state_r == pwr_pkg::ST_STAB)
        else $error("stabilization cut short");
    chk_flash_wake: assert property (FLASH_PART && state_r == pwr_pkg::ST_AHALT && !resetReq && !timebaseIrq
        |=> state_r == pwr_pkg::ST_AHALT)
        else $error("flash part woke on wrong source");
endmodule : pwr_mode_ctrl

/* File: tb/pwr_core_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// core side: instruction issue and condition codes
// ----------------------------------------
module pwr_core_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic doOp,
    input wire logic doWait,
    input wire logic [7:0] opc,
    input wire logic condMaskForce_r,
    input wire logic irqServiceReq_r,
    output logic instrValid,
    output logic [7:0] instrOpcode,
    output logic waitForIrqInstr,
    output logic [1:0] condMask,
    output logic [1:0] condStacked
);
    // idle opcode bus toggles every cycle; instrValid stays low so a stale 8E can never look executed
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            instrValid <= 1'h0;
            instrOpcode <= 8'h00;
            waitForIrqInstr <= 1'h0;
        end else begin
            instrValid <= doOp;
            instrOpcode <= doOp ? opc : ~instrOpcode;
            waitForIrqInstr <= doWait;
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            condMask <= 2'h3;
            condStacked <= 2'h0;
        end else if (condMaskForce_r) begin
            condMask <= pwr_pkg::COND_MASK_WAKE;
        end else if (irqServiceReq_r) begin
            condStacked <= condMask;
            condMask <= 2'h3;
        end
    end
endmodule : pwr_core_model

/* File: tb/power_saving_mode_control_tb_top.sv */
`timescale 1ns/1ps
module power_saving_mode_control_tb_top;
    logic clk_sys, rst, avs_read, avs_write, avs_waitrequest, doOp, doWait, instrValid, waitForIrqInstr;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [7:0] opc, instrOpcode;
    logic [13:0] irqPending, wakeFromHalt, wakeFromActHalt;
    logic timebaseIrq, resetReq, watchdogEnabled, wdgSeen;
    logic cpuClkEn_r, periphClkEn_r, timebaseClkEn_r, oscOn_r, condMaskForce_r;
    logic irqServiceReq_r, rstVectorReq_r, watchdogResetReq_r;
    logic [2:0] modeCode_r;
    logic [1:0] condMask, condStacked;
    int n_fail, compares, lat, c, p, t;
    pwr_mode_ctrl #(.FLASH_PART(1'h1)) uut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .instrValid(instrValid), .instrOpcode(instrOpcode),
        .waitForIrqInstr(waitForIrqInstr), .irqPending(irqPending), .wakeFromHalt(wakeFromHalt),
        .wakeFromActHalt(wakeFromActHalt), .timebaseIrq(timebaseIrq), .resetReq(resetReq),
        .watchdogEnabled(watchdogEnabled), .cpuClkEn_r(cpuClkEn_r), .periphClkEn_r(periphClkEn_r),
        .timebaseClkEn_r(timebaseClkEn_r), .oscOn_r(oscOn_r), .condMaskForce_r(condMaskForce_r),
        .irqServiceReq_r(irqServiceReq_r), .rstVectorReq_r(rstVectorReq_r),
        .watchdogResetReq_r(watchdogResetReq_r), .modeCode_r(modeCode_r));
    pwr_core_model core (.clk_sys(clk_sys), .rst(rst), .doOp(doOp), .doWait(doWait), .opc(opc),
        .condMaskForce_r(condMaskForce_r), .irqServiceReq_r(irqServiceReq_r), .instrValid(instrValid),
        .instrOpcode(instrOpcode), .waitForIrqInstr(waitForIrqInstr), .condMask(condMask),
        .condStacked(condStacked));
    // ----------------------------------------
    // clock, watchdog and helpers
    // ----------------------------------------
    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            wdgSeen <= 1'h0;
        end else if (watchdogResetReq_r === 1'h1) begin
            wdgSeen <= 1'h1;
        end
    end
    initial begin
        repeat (40000) @(posedge clk_sys);
        n_fail++;
        tally_and_finish();
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // request holds until the rising edge that samples waitrequest low; that edge commits a write, read data was registered on the edge before
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] rdq);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'h0 && k < 100) begin
            k++;
            @(posedge clk_sys);
        end
        rdq = avs_readdata;
        if (k >= 100) chk("waitrequest", 32'h1, 32'h0);
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        @(posedge clk_sys);
    endtask : bus
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        bus(1'h1, a, d, dummy);
    endtask : wr
    task automatic exec(input logic w, input logic [7:0] op);
        doWait <= w;
        doOp <= !w;
        opc <= op;
        @(posedge clk_sys);
        doWait <= 1'h0;
        doOp <= 1'h0;
        repeat (5) @(posedge clk_sys);
    endtask : exec
    task automatic pulses();
        c = 0;
        p = 0;
        t = 0;
        repeat (64) begin
            @(negedge clk_sys);
            c += int'(cpuClkEn_r === 1'h1);
            p += int'(periphClkEn_r === 1'h1);
            t += int'(timebaseClkEn_r === 1'h1);
        end
        @(posedge clk_sys);
    endtask : pulses
    task automatic wake();
        lat = 0;
        @(negedge clk_sys);
        while (irqServiceReq_r !== 1'h1 && rstVectorReq_r !== 1'h1 && lat < 6000) begin
            lat++;
            @(negedge clk_sys);
        end
    endtask : wake
    task automatic tally_and_finish();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {rst, avs_read, avs_write, doOp, doWait, timebaseIrq, resetReq, watchdogEnabled} = 8'h80;
        {avs_address, avs_writedata, opc, irqPending} = '0;
        wakeFromHalt = 14'h0004;
        wakeFromActHalt = 14'h0004;
        n_fail = 0;
        compares = 0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        chk("modeCode", 32'(modeCode_r), 32'(pwr_pkg::MODE_RUN));
        chk("oscOn", 32'(oscOn_r), 32'h1);
        bus(1'h0, pwr_pkg::ADDR_CLK_CTRL, 32'h0, q);
        chk("clkCtrl", q, 32'(pwr_pkg::CLK_CTRL_RST));
        wr(4'hC, 32'hF);
        bus(1'h0, 4'hC, 32'h0, q);
        chk("unmapped", q, 32'h0);
        $display("test reset done");
        for (int k = 0; k < 4; k++) begin
            wr(pwr_pkg::ADDR_CLK_CTRL, 32'((k << 1) | 1));
            bus(1'h0, pwr_pkg::ADDR_STATUS, 32'h0, q);
            chk("slowMode", q, 32'(pwr_pkg::MODE_SLOW));
            pulses();
            chk("slowRate", 32'(c >= (32 >> k) - 1 && c <= (32 >> k) + 1), 32'h1);
        end
        exec(1'h1, 8'h00);
        chk("slowWait", 32'(modeCode_r), 32'(pwr_pkg::MODE_SLOW_WAIT));
        chk("condMask", 32'(condMask), 32'(pwr_pkg::COND_MASK_WAKE));
        pulses();
        chk("cpuStopped", 32'(c), 32'h0);
        chk("periphSlow", 32'(p >= 3 && p <= 5), 32'h1);
        irqPending <= 14'h0100;
        wake();
        chk("waitIrqExit", 32'(irqServiceReq_r === 1'h1 && lat <= 2), 32'h1);
        @(posedge clk_sys);
        irqPending <= 14'h0000;
        @(posedge clk_sys);
        chk("condStacked", 32'(condStacked), 32'(pwr_pkg::COND_MASK_WAKE));
        wr(pwr_pkg::ADDR_CLK_CTRL, 32'h0);
        exec(1'h1, 8'h00);
        chk("waitMode", 32'(modeCode_r), 32'(pwr_pkg::MODE_WAIT));
        resetReq <= 1'h1;
        wake();
        chk("waitRstExit", 32'(rstVectorReq_r === 1'h1 && lat <= 2), 32'h1);
        @(posedge clk_sys);
        resetReq <= 1'h0;
        exec(1'h0, 8'h8D);
        chk("otherOpcode", 32'(modeCode_r), 32'(pwr_pkg::MODE_RUN));
        $display("test slow and wait done");
        // pending flags are already clear here
        exec(1'h0, pwr_pkg::HALT_OPCODE);
        chk("haltMode", 32'(modeCode_r), 32'(pwr_pkg::MODE_HALT));
        chk("haltMask", 32'(condMask), 32'(pwr_pkg::COND_MASK_WAKE));
        chk("oscOff", 32'(oscOn_r), 32'h0);
        pulses();
        chk("haltClocks", 32'(c + p + t), 32'h0);
        irqPending <= 14'h0100;
        repeat (20) @(posedge clk_sys);
        chk("haltUnqual", 32'(modeCode_r), 32'(pwr_pkg::MODE_HALT));
        irqPending <= 14'h0104;
        wake();
        chk("haltDelay", 32'(irqServiceReq_r === 1'h1 && lat >= 256 && lat <= 266), 32'h1);
        @(posedge clk_sys);
        irqPending <= 14'h0000;
        $display("test halt done");
        watchdogEnabled <= 1'h1;
        wr(pwr_pkg::ADDR_CLK_CTRL, 32'h8);
        exec(1'h0, pwr_pkg::HALT_OPCODE);
        chk("actHalt", 32'(modeCode_r), 32'(pwr_pkg::MODE_ACT_HALT));
        pulses();
        chk("actClocks", 32'(c == 0 && p == 0 && t > 0 && oscOn_r === 1'h1), 32'h1);
        chk("noWdgReset", 32'(wdgSeen), 32'h0);
        irqPending <= 14'h0004;
        repeat (20) @(posedge clk_sys);
        chk("flashWake", 32'(modeCode_r), 32'(pwr_pkg::MODE_ACT_HALT));
        timebaseIrq <= 1'h1;
        wake();
        chk("actIrqExit", 32'(irqServiceReq_r === 1'h1 && lat <= 2), 32'h1);
        @(posedge clk_sys);
        {timebaseIrq, irqPending} <= 15'h0000;
        repeat (300) @(posedge clk_sys); // osc irq enable left set past the delay
        wr(pwr_pkg::ADDR_OPTION, 32'h1);
        exec(1'h0, pwr_pkg::HALT_OPCODE);
        resetReq <= 1'h1;
        wake();
        chk("actRstExit", 32'(rstVectorReq_r === 1'h1 && lat >= 4096 && lat <= 4106), 32'h1);
        @(posedge clk_sys);
        resetReq <= 1'h0;
        $display("test active halt done");
        wr(pwr_pkg::ADDR_OPTION, 32'h2);
        wr(pwr_pkg::ADDR_CLK_CTRL, 32'h0);
        exec(1'h0, pwr_pkg::HALT_OPCODE);
        chk("wdgReset", 32'(wdgSeen === 1'h1 && modeCode_r === pwr_pkg::MODE_RUN), 32'h1);
        rst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        rst <= 1'h0;
        @(posedge clk_sys);
        bus(1'h0, pwr_pkg::ADDR_OPTION, 32'h0, q);
        chk("optReset", q, 32'(pwr_pkg::OPTION_RST));
        chk("rerunMode", 32'(modeCode_r), 32'(pwr_pkg::MODE_RUN));
        $display("test watchdog and reset done");
        tally_and_finish();
    end
endmodule : power_saving_mode_control_tb_top
